// [hw/tsmr_pkg.sv]
`default_nettype none
package tsmr_pkg;
	// ----------------------------------------------------------------
	// register indices (byte address = 4 * index)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_REVISION  = 6'h37;
	localparam logic [5:0] IDX_PIN_SEL   = 6'h38;
	localparam logic [5:0] IDX_DAC_ONE   = 6'h39;
	localparam logic [5:0] IDX_DAC_TWO   = 6'h3a;
	localparam logic [5:0] IDX_ADC_SNAP  = 6'h3b;
	localparam logic [5:0] IDX_PROD_A    = 6'h3c;
	localparam logic [5:0] IDX_PROD_B    = 6'h3d;
	localparam logic [5:0] IDX_PROD_C    = 6'h3e;
	localparam logic [5:0] IDX_PROD_D    = 6'h3f;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int SEL_ONE_LSB = 4;
	localparam int SEL_TWO_LSB = 0;
	localparam int ADC_I_LSB   = 4;
	localparam int ADC_Q_LSB   = 0;
	localparam int DAC_W       = 6;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] PIN_SEL_RESET = 8'h00;
	localparam logic [5:0] DAC_RESET     = 6'h00;
	localparam logic [7:0] PROD_A_RESET  = 8'hff;
	localparam logic [7:0] PROD_B_RESET  = 8'h00;
	localparam logic [7:0] PROD_C_RESET  = 8'h03;
	localparam logic [7:0] PROD_D_RESET  = 8'h00;

	// ----------------------------------------------------------------
	// pin select codes
	// ----------------------------------------------------------------
	localparam logic [3:0] SEL_HIGHZ  = 4'h0;
	localparam logic [3:0] SEL_DAC    = 4'h1;
	localparam logic [3:0] SEL_CORR   = 4'h2;
	localparam logic [3:0] SEL_FLOOR  = 4'h4;
	localparam logic [3:0] SEL_ADC_I  = 4'h5;
	localparam logic [3:0] SEL_ADC_Q  = 4'h6;
	localparam logic [3:0] SEL_HIGH   = 4'ha;
	localparam logic [3:0] SEL_LOW    = 4'hb;
	localparam logic [3:0] SEL_SEND   = 4'hc;
	localparam logic [3:0] SEL_RECV   = 4'hd;
	localparam logic [3:0] SEL_SUBC   = 4'he;
	localparam logic [3:0] SEL_PROBE  = 4'hf;

	// link rate codes
	localparam logic [1:0] RATE_106 = 2'h0;
endpackage : tsmr_pkg
`default_nettype wire

// [hw/tsmr_sync3.sv]
`default_nettype none
module tsmr_sync3 import tsmr_pkg::*; #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         clk_in,
	input  wire logic         reset_in,
	// foreign-domain word
	input  wire logic [W-1:0] async_in,
	// settled copy
	output logic      [W-1:0] value_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} tsmr_sync_s;

	tsmr_sync_s st;
	tsmr_sync_s next_st;

	always_comb begin
		next_st    = st;
		next_st.s1 = async_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// take a change only once two stages agree
		if (st.s2 == st.s3) begin
			next_st.q = st.s3;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign value_out = st.q;
endmodule : tsmr_sync3
`default_nettype wire

// [hw/tsmr_pin_mux.sv]
`default_nettype none
module tsmr_pin_mux import tsmr_pkg::*; (
	// code for this pin
	input  wire logic [3:0]       sel_in,
	// candidate sources
	input  wire logic [DAC_W-1:0] dac_value_in,
	input  wire logic [3:0]       floor_in,
	input  wire logic [3:0]       adc_i_in,
	input  wire logic [3:0]       adc_q_in,
	input  wire logic             corr_in,
	input  wire logic             send_in,
	input  wire logic             recv_in,
	input  wire logic             subc_in,
	input  wire logic             rate_is_106_in,
	input  wire logic             probe_bit_in,
	// pin drive
	output logic                  level_out,
	output logic                  oe_n_out,
	output logic [DAC_W-1:0]      code_out,
	output logic                  dac_en_out
);
	always_comb begin
		level_out  = 1'b0;
		oe_n_out   = 1'b1;
		code_out   = '0;
		dac_en_out = 1'b0;
		case (sel_in)
			SEL_DAC: begin
				code_out   = dac_value_in;
				dac_en_out = 1'b1;
			end
			SEL_FLOOR: begin
				code_out   = {2'h0, floor_in};
				dac_en_out = 1'b1;
			end
			SEL_ADC_I: begin
				code_out   = {2'h0, adc_i_in};
				dac_en_out = 1'b1;
			end
			SEL_ADC_Q: begin
				code_out   = {2'h0, adc_q_in};
				dac_en_out = 1'b1;
			end
			SEL_CORR: begin
				level_out = corr_in;
				oe_n_out  = 1'b0;
			end
			SEL_HIGH: begin
				level_out = 1'b1;
				oe_n_out  = 1'b0;
			end
			SEL_LOW: begin
				oe_n_out = 1'b0;
			end
			SEL_SEND: begin
				level_out = send_in;
				oe_n_out  = 1'b0;
			end
			SEL_RECV: begin
				level_out = recv_in;
				oe_n_out  = 1'b0;
			end
			SEL_SUBC: begin
				// meaningless at the slowest rate, held low there
				level_out = subc_in & ~rate_is_106_in;
				oe_n_out  = 1'b0;
			end
			SEL_PROBE: begin
				level_out = probe_bit_in;
				oe_n_out  = 1'b0;
			end
			default: begin
				// high impedance and reserved codes float the pin
				oe_n_out = 1'b1;
			end
		endcase
	end
endmodule : tsmr_pin_mux
`default_nettype wire

// [hw/tsmr_top.sv]
// Summary of operation
// [R1] A read-only 8-bit register reports the firmware revision and ignores writes.
// [R2] Code 0001 in the first pin field puts converter one on pin one and converter two on pin two.
// [R3] Codes 0100, 0101, 0110 route the receiver floor, I channel and Q channel via the converter.
// [R4] Code 1100 shows the sending indicator, shaped per link rate by the transmitter.
// [R5] Code 1101 shows the receiving indicator, shaped per link rate by the receiver.
// [R6] Code 1110 shows subcarrier detection, undefined at the slowest rate.
// [R7] Code 1111 shows the probe bus bit picked by the external bit choice.
// [R8] The low select nibble drives pin two with the same code table as the high nibble for pin one.
// [R9] Converter one holds a 6-bit value shown on pin one under code 0001.
// [R10] Converter two holds a 6-bit value shown on pin two under code 0001.
// [R11] A read-only register returns the I channel in bits 7..4 and Q channel in bits 3..0.
// [R12] Production test registers hold their reset values and steer nothing; here they take APB writes.
// [R13] Code 0000 floats the pin, 1010 drives high, 1011 drives low, reserved codes float.
`default_nettype none
module tsmr_top import tsmr_pkg::*; #(
	parameter logic [7:0] REVISION = 8'h5a  // arbitrary value
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	// apb slave
	input  wire logic             psel_in,
	input  wire logic             penable_in,
	input  wire logic             pwrite_in,
	input  wire logic [7:0]       paddr_in,
	input  wire logic [31:0]      pwdata_in,
	output logic                  pready_out,
	output logic      [31:0]      prdata_out,
	output logic                  pslverr_out,
	// internal test sources, same clock
	input  wire logic [3:0]       receiver_floor_signal_in,
	input  wire logic             correlator_one_signal_in,
	input  wire logic             sending_indicator_in,
	input  wire logic             receiving_indicator_in,
	input  wire logic             subcarrier_detected_in,
	input  wire logic [1:0]       link_rate_in,
	input  wire logic [7:0]       probe_bus_in,
	input  wire logic [2:0]       probe_bus_bit_choice_in,
	// converter channels, foreign domain
	input  wire logic [3:0]       adc_i_in,
	input  wire logic [3:0]       adc_q_in,
	// first test pin
	output logic                  first_test_output_pin_out,
	output logic                  first_test_output_pin_oe_n_out,
	output logic      [DAC_W-1:0] first_test_output_pin_code_out,
	output logic                  first_test_output_pin_dac_en_out,
	// second test pin
	output logic                  second_test_output_pin_out,
	output logic                  second_test_output_pin_oe_n_out,
	output logic      [DAC_W-1:0] second_test_output_pin_code_out,
	output logic                  second_test_output_pin_dac_en_out
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]       pin_sel;
		logic [DAC_W-1:0] first_test_converter_value;
		logic [DAC_W-1:0] second_test_converter_value;
		logic [7:0]       prod_a;
		logic [7:0]       prod_b;
		logic [7:0]       prod_c;
		logic [7:0]       prod_d;
		logic             ready;
		logic             slverr;
		logic [31:0]      rdata;
		logic             p1_level;
		logic             p1_oe_n;
		logic [DAC_W-1:0] p1_code;
		logic             p1_dac_en;
		logic             p2_level;
		logic             p2_oe_n;
		logic [DAC_W-1:0] p2_code;
		logic             p2_dac_en;
	} tsmr_top_s;

	tsmr_top_s        st;
	tsmr_top_s        next_st;
	logic [7:0]       adc_snap;
	logic [3:0]       first_pin_signal_select;
	logic [3:0]       second_pin_signal_select;
	logic [3:0]       second_sel_eff;
	logic             rate_is_106;
	logic             probe_bit;
	logic             m1_level;
	logic             m1_oe_n;
	logic [DAC_W-1:0] m1_code;
	logic             m1_dac_en;
	logic             m2_level;
	logic             m2_oe_n;
	logic [DAC_W-1:0] m2_code;
	logic             m2_dac_en;
	logic [5:0]       idx;
	logic             setup;
	logic             access;

	// ----------------------------------------------------------------
	// converter snapshot crossing
	// ----------------------------------------------------------------
	tsmr_sync3 #(.W(8)) u_adc_sync (
		.clk_in    (clk_in),
		.reset_in  (reset_in),
		.async_in  ({adc_i_in, adc_q_in}),
		.value_out (adc_snap)
	);

	// ----------------------------------------------------------------
	// pin routing
	// ----------------------------------------------------------------
	assign first_pin_signal_select  = st.pin_sel[SEL_ONE_LSB +: 4];
	assign second_pin_signal_select = st.pin_sel[SEL_TWO_LSB +: 4];
	// converter mode on pin one pulls pin two onto converter two
	assign second_sel_eff = (first_pin_signal_select == SEL_DAC) ?
		SEL_DAC : second_pin_signal_select;  // see [R2] see [R8]
	assign rate_is_106 = (link_rate_in == RATE_106);  // see [R6]
	assign probe_bit   = probe_bus_in[probe_bus_bit_choice_in];  // see [R7]

	tsmr_pin_mux u_mux_one (
		.sel_in         (first_pin_signal_select),
		.dac_value_in   (st.first_test_converter_value),
		.floor_in       (receiver_floor_signal_in),
		.adc_i_in       (adc_snap[ADC_I_LSB +: 4]),
		.adc_q_in       (adc_snap[ADC_Q_LSB +: 4]),
		.corr_in        (correlator_one_signal_in),
		.send_in        (sending_indicator_in),
		.recv_in        (receiving_indicator_in),
		.subc_in        (subcarrier_detected_in),
		.rate_is_106_in (rate_is_106),
		.probe_bit_in   (probe_bit),
		.level_out      (m1_level),
		.oe_n_out       (m1_oe_n),
		.code_out       (m1_code),
		.dac_en_out     (m1_dac_en)
	);

	tsmr_pin_mux u_mux_two (
		.sel_in         (second_sel_eff),
		.dac_value_in   (st.second_test_converter_value),
		.floor_in       (receiver_floor_signal_in),
		.adc_i_in       (adc_snap[ADC_I_LSB +: 4]),
		.adc_q_in       (adc_snap[ADC_Q_LSB +: 4]),
		.corr_in        (correlator_one_signal_in),
		.send_in        (sending_indicator_in),
		.recv_in        (receiving_indicator_in),
		.subc_in        (subcarrier_detected_in),
		.rate_is_106_in (rate_is_106),
		.probe_bit_in   (probe_bit),
		.level_out      (m2_level),
		.oe_n_out       (m2_oe_n),
		.code_out       (m2_code),
		.dac_en_out     (m2_dac_en)
	);

	// ----------------------------------------------------------------
	// register file and apb
	// ----------------------------------------------------------------
	assign idx    = paddr_in[7:2];
	assign setup  = psel_in & ~penable_in;
	assign access = psel_in & penable_in & st.ready;

	always_comb begin
		next_st       = st;
		next_st.ready = setup;
		// answer prepared in setup, shown in the first access cycle
		if (setup) begin
			next_st.slverr = (paddr_in[1:0] != 2'h0);
			next_st.rdata  = '0;
			case (idx)
				IDX_REVISION: next_st.rdata[7:0] = REVISION;  // see [R1]
				IDX_PIN_SEL:  next_st.rdata[7:0] = st.pin_sel;
				IDX_DAC_ONE:  next_st.rdata[DAC_W-1:0] = st.first_test_converter_value;
				IDX_DAC_TWO:  next_st.rdata[DAC_W-1:0] = st.second_test_converter_value;
				IDX_ADC_SNAP: next_st.rdata[7:0] = adc_snap;  // see [R11]
				IDX_PROD_A:   next_st.rdata[7:0] = st.prod_a;
				IDX_PROD_B:   next_st.rdata[7:0] = st.prod_b;
				IDX_PROD_C:   next_st.rdata[7:0] = st.prod_c;
				IDX_PROD_D:   next_st.rdata[7:0] = st.prod_d;
				default:      next_st.slverr = 1'b1;
			endcase
		end
		// revision and snapshot ignore writes
		if (access && pwrite_in && !st.slverr) begin
			case (idx)
				IDX_PIN_SEL: next_st.pin_sel = pwdata_in[7:0];
				IDX_DAC_ONE:  // see [R9]
					next_st.first_test_converter_value = pwdata_in[DAC_W-1:0];
				IDX_DAC_TWO:  // see [R10]
					next_st.second_test_converter_value = pwdata_in[DAC_W-1:0];
				// kept as storage only, readable over apb but steering nothing
				IDX_PROD_A: next_st.prod_a = pwdata_in[7:0];  // see [R12]
				IDX_PROD_B: next_st.prod_b = pwdata_in[7:0];
				IDX_PROD_C: next_st.prod_c = pwdata_in[7:0];
				IDX_PROD_D: next_st.prod_d = pwdata_in[7:0];
				default: begin
				end
			endcase
		end
		// registered pin drive, one cycle behind the select
		next_st.p1_level  = m1_level;  // see [R3] see [R4] see [R5]
		next_st.p1_oe_n   = m1_oe_n;  // see [R13]
		next_st.p1_code   = m1_code;
		next_st.p1_dac_en = m1_dac_en;
		next_st.p2_level  = m2_level;
		next_st.p2_oe_n   = m2_oe_n;
		next_st.p2_code   = m2_code;
		next_st.p2_dac_en = m2_dac_en;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st         <= '0;
			st.pin_sel <= PIN_SEL_RESET;
			st.first_test_converter_value  <= DAC_RESET;
			st.second_test_converter_value <= DAC_RESET;
			st.prod_a  <= PROD_A_RESET;
			st.prod_b  <= PROD_B_RESET;
			st.prod_c  <= PROD_C_RESET;
			st.prod_d  <= PROD_D_RESET;
			st.p1_oe_n <= 1'b1;
			st.p2_oe_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign pready_out  = st.ready;
	assign prdata_out  = st.rdata;
	assign pslverr_out = st.slverr;
	assign first_test_output_pin_out         = st.p1_level;
	assign first_test_output_pin_oe_n_out    = st.p1_oe_n;
	assign first_test_output_pin_code_out    = st.p1_code;
	assign first_test_output_pin_dac_en_out  = st.p1_dac_en;
	assign second_test_output_pin_out        = st.p2_level;
	assign second_test_output_pin_oe_n_out   = st.p2_oe_n;
	assign second_test_output_pin_code_out   = st.p2_code;
	assign second_test_output_pin_dac_en_out = st.p2_dac_en;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	sequence seq_setup(logic [5:0] i, logic wr);
		psel_in && !penable_in && pwrite_in == wr && idx == i && paddr_in[1:0] == 2'h0;
	endsequence

	sequence seq_access;
		psel_in && penable_in && pready_out;
	endsequence

	AST_REVISION_READ: assert property ( // see [R1]
		seq_setup(IDX_REVISION, 1'b0) |=> pready_out && prdata_out == {24'h0, REVISION}
	) else $error("revision read wrong");

	AST_ONE_DRIVES_TWO: assert property ( // see [R2]
		first_pin_signal_select == SEL_DAC |=>
		second_test_output_pin_dac_en_out &&
		second_test_output_pin_code_out == $past(st.second_test_converter_value)
	) else $error("pin two not on converter two");

	AST_ADC_I_ROUTE: assert property ( // see [R3]
		first_pin_signal_select == SEL_ADC_I |=>
		first_test_output_pin_code_out == {2'h0, $past(adc_snap[7:4])}
	) else $error("i channel not routed");

	AST_SEND_ROUTE: assert property ( // see [R4]
		first_pin_signal_select == SEL_SEND |=>
		!first_test_output_pin_oe_n_out &&
		first_test_output_pin_out == $past(sending_indicator_in)
	) else $error("sending indicator not routed");

	AST_RECV_ROUTE: assert property ( // see [R5]
		second_sel_eff == SEL_RECV |=>
		second_test_output_pin_out == $past(receiving_indicator_in)
	) else $error("receiving indicator not routed");

	AST_SUBC_SLOW: assert property ( // see [R6]
		first_pin_signal_select == SEL_SUBC && rate_is_106 |=> !first_test_output_pin_out
	) else $error("subcarrier shown at slowest rate");

	AST_PROBE_BIT: assert property ( // see [R7]
		first_pin_signal_select == SEL_PROBE |=>
		first_test_output_pin_out == $past(probe_bus_in[probe_bus_bit_choice_in])
	) else $error("probe bit not routed");

	AST_PIN_TWO_HIGH: assert property ( // see [R8]
		first_pin_signal_select != SEL_DAC && second_pin_signal_select == SEL_HIGH |=>
		second_test_output_pin_out && !second_test_output_pin_oe_n_out
	) else $error("pin two not high");

	AST_DAC_ONE_WRITE: assert property ( // see [R9]
		seq_setup(IDX_DAC_ONE, 1'b1) ##1 seq_access |=>
		st.first_test_converter_value == $past(pwdata_in[5:0])
	) else $error("converter one write lost");

	AST_DAC_TWO_WRITE: assert property ( // see [R10]
		seq_setup(IDX_DAC_TWO, 1'b1) ##1 seq_access |=>
		st.second_test_converter_value == $past(pwdata_in[5:0])
	) else $error("converter two write lost");

	AST_ADC_READ: assert property ( // see [R11]
		seq_setup(IDX_ADC_SNAP, 1'b0) |=> prdata_out == {24'h0, $past(adc_snap)}
	) else $error("snapshot read wrong");

	AST_PROD_RESET: assert property ( // see [R12]
		@(posedge clk_in) disable iff (1'b0)
		reset_in |=> st.prod_a == PROD_A_RESET && st.prod_c == PROD_C_RESET
	) else $error("production reset value wrong");

	AST_HIGHZ: assert property ( // see [R13]
		first_pin_signal_select == SEL_HIGHZ |=> first_test_output_pin_oe_n_out [*1]
	) else $error("pin one not floating");
endmodule : tsmr_top
`default_nettype wire

// [verification/testbench.sv]
`default_nettype none
module testbench import tsmr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	localparam logic [7:0] REV = 8'h3c;  // arbitrary value
	logic        clk_in     = 1'b0;
	logic        reset_in   = 1'b1;
	logic        psel_in    = 1'b0;
	logic        penable_in = 1'b0;
	logic        pwrite_in  = 1'b0;
	logic [7:0]  paddr_in   = 8'h00;
	logic [31:0] pwdata_in  = 32'h0;
	logic        pready_out;
	logic [31:0] prdata_out;
	logic        pslverr_out;
	logic [3:0]  floor      = 4'h0;
	logic        corr       = 1'b0;
	logic        send       = 1'b0;
	logic        recv       = 1'b0;
	logic        subc       = 1'b0;
	logic [1:0]  rate       = 2'h0;
	logic [7:0]  probe      = 8'h00;
	logic [2:0]  choice     = 3'h0;
	logic [3:0]  adc_i      = 4'h0;
	logic [3:0]  adc_q      = 4'h0;
	logic        p1_lvl, p1_oe_n, p1_dac, p2_lvl, p2_oe_n, p2_dac;
	logic [5:0]  p1_code, p2_code;
	integer      seed = 32'h60dc5920;
	int          fails = 0;
	int          comparisons = 0;

	tsmr_top #(.REVISION(REV)) i_tsmr_top (
		.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
		.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
		.pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
		.receiver_floor_signal_in(floor), .correlator_one_signal_in(corr),
		.sending_indicator_in(send), .receiving_indicator_in(recv),
		.subcarrier_detected_in(subc), .link_rate_in(rate), .probe_bus_in(probe),
		.probe_bus_bit_choice_in(choice), .adc_i_in(adc_i), .adc_q_in(adc_q),
		.first_test_output_pin_out(p1_lvl), .first_test_output_pin_oe_n_out(p1_oe_n),
		.first_test_output_pin_code_out(p1_code), .first_test_output_pin_dac_en_out(p1_dac),
		.second_test_output_pin_out(p2_lvl), .second_test_output_pin_oe_n_out(p2_oe_n),
		.second_test_output_pin_code_out(p2_code), .second_test_output_pin_dac_en_out(p2_dac)
	);

	initial begin
		forever #2.5 clk_in = ~clk_in;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic end_of_test;
		if (fails == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// read data is checked only on reads; writes look at the ready and error flags alone
	task automatic xfer(input string nm, input logic w, input logic [7:0] a,
			input logic [31:0] d, input logic [31:0] erd, input logic eerr);
		logic [31:0] rd;
		logic        err;
		int          n;
		n = 0;
		@(posedge clk_in);
		psel_in    <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in  <= w;
		paddr_in   <= a;
		pwdata_in  <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 20);
		rd  = prdata_out;
		err = pslverr_out;
		psel_in    <= 1'b0;
		penable_in <= 1'b0;
		check("pready", {31'h0, pready_out}, 32'h1);
		check({nm, "_err"}, {31'h0, err}, {31'h0, eerr});
		if (!w)
			check(nm, rd, erd);
	endtask : xfer

	task automatic rand_src(input logic slow);
		logic [31:0] r;
		r = $random(seed);
		@(posedge clk_in);
		floor  <= r[3:0];
		corr   <= r[4];
		send   <= r[5];
		recv   <= r[6];
		subc   <= r[7];
		rate   <= slow ? RATE_106 : r[9:8];
		probe  <= r[17:10];
		choice <= r[20:18];
		adc_i  <= r[24:21];
		adc_q  <= r[28:25];
	endtask : rand_src

	task automatic do_reset;
		@(posedge clk_in);
		reset_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		reset_in <= 1'b0;
	endtask : do_reset

	// ----------------------------------------------------------------
	// pin model: {oe_n, level, dac_en, code}, every bit compared
	// ----------------------------------------------------------------
	function automatic logic [8:0] pin_exp(input logic [3:0] c, input logic [5:0] dv);
		logic lvl;
		lvl = 1'b0;
		case (c)
			4'h1: return {3'b101, dv};
			4'h4: return {5'b10100, floor};
			4'h5: return {5'b10100, adc_i};
			4'h6: return {5'b10100, adc_q};
			4'h2: lvl = corr;
			4'ha: lvl = 1'b1;
			4'hb: lvl = 1'b0;
			4'hc: lvl = send;
			4'hd: lvl = recv;
			4'he: lvl = (rate == 2'h0) ? 1'b0 : subc;
			4'hf: lvl = probe[choice];
			default: return 9'h100;
		endcase
		return {1'b0, lvl, 7'h00};
	endfunction : pin_exp

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	logic [5:0] ridx [7] = '{IDX_PIN_SEL, IDX_DAC_ONE, IDX_DAC_TWO, IDX_PROD_A, IDX_PROD_B,
		IDX_PROD_C, IDX_PROD_D};
	logic [7:0] rval [7] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h03, 8'h00};

	initial begin
		logic [31:0] d1, d2;
		logic [3:0]  c1, c2, c2e;
		logic [8:0]  x1, x2, s1, s2;
		repeat (4) @(posedge clk_in);
		reset_in <= 1'b0;
		#1;
		check("pin_reset", {30'h0, p1_oe_n, p2_oe_n}, 32'h3);
		xfer("rev", 1'b0, {IDX_REVISION, 2'b00}, 0, 32'(REV), 1'b0);
		for (int k = 0; k < 7; k++)
			xfer("rst", 1'b0, {ridx[k], 2'b00}, 0, 32'(rval[k]), 1'b0);
		xfer("rev_w", 1'b1, {IDX_REVISION, 2'b00}, 32'hff, 0, 1'b0);
		xfer("rev", 1'b0, {IDX_REVISION, 2'b00}, 0, 32'(REV), 1'b0);
		xfer("adc_w", 1'b1, {IDX_ADC_SNAP, 2'b00}, 32'hff, 0, 1'b0);
		xfer("unmapped", 1'b0, 8'h00, 0, 32'h0, 1'b1);
		xfer("misalign", 1'b1, 8'he1, 32'h11, 0, 1'b1);
		// a refused write must leave the select untouched
		xfer("sel_kept", 1'b0, {IDX_PIN_SEL, 2'b00}, 0, 32'h0, 1'b0);
		// both fields walk all sixteen codes; pairing shifts every sixteen passes
		for (int i = 0; i < 64; i++) begin
			c1 = i[3:0];
			c2 = 4'(i * 7 + 3 + (i >> 4));
			d1 = $random(seed);
			d2 = $random(seed);
			// first block holds the slowest rate so code 1110 meets it
			rand_src(i < 16);
			xfer("dac1_w", 1'b1, {IDX_DAC_ONE, 2'b00}, d1, 0, 1'b0);
			xfer("dac2_w", 1'b1, {IDX_DAC_TWO, 2'b00}, d2, 0, 1'b0);
			xfer("sel_w", 1'b1, {IDX_PIN_SEL, 2'b00}, {24'h0, c1, c2}, 0, 1'b0);
			xfer("dac1", 1'b0, {IDX_DAC_ONE, 2'b00}, 0, {26'h0, d1[5:0]}, 1'b0);
			xfer("dac2", 1'b0, {IDX_DAC_TWO, 2'b00}, 0, {26'h0, d2[5:0]}, 1'b0);
			xfer("sel", 1'b0, {IDX_PIN_SEL, 2'b00}, 0, {24'h0, c1, c2}, 1'b0);
			xfer("adc", 1'b0, {IDX_ADC_SNAP, 2'b00}, 0, {24'h0, adc_i, adc_q}, 1'b0);
			#1;
			c2e = (c1 == 4'h1) ? 4'h1 : c2;
			x1 = pin_exp(c1, d1[5:0]);
			x2 = pin_exp(c2e, d2[5:0]);
			s1 = {p1_oe_n, p1_lvl, p1_dac, p1_code};
			s2 = {p2_oe_n, p2_lvl, p2_dac, p2_code};
			check("pin_one", 32'(s1), 32'(x1));
			check("pin_two", 32'(s2), 32'(x2));
		end
		// a second reset after traffic must restore the table
		do_reset();
		#1;
		check("pin_rst2", {30'h0, p1_oe_n, p2_oe_n}, 32'h3);
		xfer("sel_rst", 1'b0, {IDX_PIN_SEL, 2'b00}, 0, 32'h0, 1'b0);
		xfer("dac1_rst", 1'b0, {IDX_DAC_ONE, 2'b00}, 0, 32'h0, 1'b0);
		end_of_test();
	end

	// run is under two thousand cycles; this 40000-cycle limit is over twenty times that
	initial begin
		#200000;
		fails++;
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
